// File: hw/scr_pkg.sv
// Constants for the start-up clock and reset sequencer
// Assumes one 10 MHz reference clock and a classic Wishbone register port
package scr_pkg;
	// ----------------------------------------
	// Register map (word aligned)
	// ----------------------------------------
	localparam logic [7:0] ADDR_RUN_RST_CTL = 8'h00;
	localparam logic [7:0] ADDR_PWR_MGMT_CTL = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam int RUN_RST_EN_BIT = 0;
	localparam int PM_MULT_LSB = 0;
	localparam int PM_DIV_LSB = 8;
	localparam int ST_RUN_BIT = 0;
	localparam int ST_RATIO_LSB = 1;
	localparam int ST_BOOT_LSB = 3;
	localparam int ST_FREQ_SET_BIT = 6;
	// ----------------------------------------
	// Ratio strap encodings
	// ----------------------------------------
	localparam logic [1:0] RATIO_CODE_8 = 2'h0;
	localparam logic [1:0] RATIO_CODE_32 = 2'h1;
	localparam logic [1:0] RATIO_CODE_16 = 2'h2;
	localparam logic [7:0] RATIO_MULT_8 = 8'h08;
	localparam logic [7:0] RATIO_MULT_16 = 8'h10;
	localparam logic [7:0] RATIO_MULT_32 = 8'h20;
	localparam logic [7:0] RESET_DIV = 8'h01;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int LOCK_CYCLES = 4096;
	localparam logic [31:0] RESET_VECTOR = 32'h0009_0000;
	typedef enum logic [1:0] {ST_HELD, ST_LOCK, ST_RUN} scr_state_t;
endpackage

// File: hw/scr_sync2.sv
// Two-stage synchroniser for pin levels
// Assumes inputs asynchronous to mclk
`timescale 1ns/1ns
`default_nettype none
module scr_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	if (WIDTH < 1) begin : g_width_chk
		$error("WIDTH must be positive");
	end
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= meta_d;
			sync_out <= sync_d;
		end
	end
endmodule
`default_nettype wire

// File: hw/scr_startup.sv
// Start-up sequencer: straps, lock delay, reset vector, dual reset pin
// Assumes hardware reset pin and straps come from the board asynchronously
`timescale 1ns/1ns
`default_nettype none
module scr_startup #(
	parameter int LOCK_COUNT = scr_pkg::LOCK_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic hw_reset_n,
	input wire logic [1:0] ratio_strap,
	input wire logic [2:0] boot_strap,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe_n,
	output logic core_reset,
	output logic core_fetch_start,
	output logic [31:0] core_fetch_addr,
	output logic [7:0] pll_mult,
	output logic [7:0] pll_div,
	output logic [2:0] boot_mode,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	// Counter is 16 bits wide
	if (LOCK_COUNT < 1 || LOCK_COUNT > 65535) begin : g_lock_chk
		$error("LOCK_COUNT out of range");
	end
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [6:0] pins_s;
	scr_sync2 #(.WIDTH(7)) u_sync (
		.mclk(mclk),
		.srst(srst),
		.async_in({reset_pin_in, boot_strap, ratio_strap, hw_reset_n}),
		.sync_out(pins_s)
	);
	logic rst_n_s;
	logic [1:0] ratio_s;
	logic [2:0] boot_s;
	logic run_rst_s;
	assign rst_n_s = pins_s[0];
	assign ratio_s = pins_s[2:1];
	assign boot_s = pins_s[5:3];
	assign run_rst_s = ~pins_s[6];

	function automatic logic [7:0] ratio_mult(input logic [1:0] code);
		unique case (code)
			scr_pkg::RATIO_CODE_8: ratio_mult = scr_pkg::RATIO_MULT_8;
			scr_pkg::RATIO_CODE_32: ratio_mult = scr_pkg::RATIO_MULT_32;
			scr_pkg::RATIO_CODE_16: ratio_mult = scr_pkg::RATIO_MULT_16;
			// Reserved code: fall back to slowest ratio
			default: ratio_mult = scr_pkg::RATIO_MULT_8;
		endcase
	endfunction

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	scr_pkg::scr_state_t state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic [1:0] ratio_q, ratio_d;
	logic [2:0] boot_q, boot_d;
	logic run_en_q, run_en_d;
	logic [7:0] mult_q, mult_d, div_q, div_d;
	logic freq_set_q, freq_set_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic fetch_q, fetch_d;
	logic held;
	logic wr;
	// Running reset acts only once the pin has become an input
	assign held = ~rst_n_s | (run_en_q & run_rst_s);
	// Write lands on the edge that samples ack high
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		ratio_d = ratio_q;
		boot_d = boot_q;
		fetch_d = 1'b0;
		mult_d = mult_q;
		div_d = div_q;
		freq_set_d = freq_set_q;
		unique case (state_q)
			scr_pkg::ST_HELD: begin
				// Straps captured while held; board keeps them valid
				ratio_d = ratio_s;
				boot_d = boot_s;
				mult_d = ratio_mult(ratio_s);
				div_d = scr_pkg::RESET_DIV;
				freq_set_d = 1'b0;
				cnt_d = '0;
				if (!held) state_d = scr_pkg::ST_LOCK;
			end
			scr_pkg::ST_LOCK: begin
				cnt_d = cnt_q + 16'h0001;
				if (cnt_q == 16'(LOCK_COUNT - 1)) begin
					state_d = scr_pkg::ST_RUN;
					fetch_d = 1'b1;
				end
			end
			scr_pkg::ST_RUN: begin
				// Frequency writes accepted only while running
				if (wr && wb_adr_i == scr_pkg::ADDR_PWR_MGMT_CTL) begin
					mult_d = wb_dat_i[scr_pkg::PM_MULT_LSB +: 8];
					div_d = wb_dat_i[scr_pkg::PM_DIV_LSB +: 8];
					freq_set_d = 1'b1;
				end
			end
		endcase
		// No fetch pulse when reset cuts the last lock cycle
		if (held && state_q != scr_pkg::ST_HELD) begin
			state_d = scr_pkg::ST_HELD;
			fetch_d = 1'b0;
		end
	end

	// ----------------------------------------
	// Wishbone slave: one-cycle ack, unmapped reads zero
	// ----------------------------------------
	always_comb begin
		run_en_d = run_en_q;
		ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
		rdat_d = '0;
		if (wr && wb_adr_i == scr_pkg::ADDR_RUN_RST_CTL) begin
			run_en_d = wb_dat_i[scr_pkg::RUN_RST_EN_BIT];
		end
		unique case (wb_adr_i)
			scr_pkg::ADDR_RUN_RST_CTL: rdat_d[scr_pkg::RUN_RST_EN_BIT] = run_en_q;
			scr_pkg::ADDR_PWR_MGMT_CTL: begin
				rdat_d[scr_pkg::PM_MULT_LSB +: 8] = mult_q;
				rdat_d[scr_pkg::PM_DIV_LSB +: 8] = div_q;
			end
			scr_pkg::ADDR_STATUS: begin
				rdat_d[scr_pkg::ST_RUN_BIT] = (state_q == scr_pkg::ST_RUN);
				rdat_d[scr_pkg::ST_RATIO_LSB +: 2] = ratio_q;
				rdat_d[scr_pkg::ST_BOOT_LSB +: 3] = boot_q;
				rdat_d[scr_pkg::ST_FREQ_SET_BIT] = freq_set_q;
			end
			default: rdat_d = '0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= scr_pkg::ST_HELD;
			cnt_q <= '0;
			ratio_q <= '0;
			boot_q <= '0;
			run_en_q <= 1'b0;
			mult_q <= scr_pkg::RATIO_MULT_8;
			div_q <= scr_pkg::RESET_DIV;
			freq_set_q <= 1'b0;
			ack_q <= 1'b0;
			rdat_q <= '0;
			fetch_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			ratio_q <= ratio_d;
			boot_q <= boot_d;
			run_en_q <= run_en_d;
			mult_q <= mult_d;
			div_q <= div_d;
			freq_set_q <= freq_set_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			fetch_q <= fetch_d;
		end
	end

	// ----------------------------------------
	// Pin and core outputs
	// ----------------------------------------
	logic core_reset_q, pin_out_q, pin_oe_n_q;
	always_ff @(posedge mclk) begin
		if (srst) begin
			core_reset_q <= 1'b1;
			pin_out_q <= 1'b0;
			pin_oe_n_q <= 1'b0;
		end else begin
			core_reset_q <= (state_d != scr_pkg::ST_RUN);
			pin_out_q <= (state_d == scr_pkg::ST_RUN);
			pin_oe_n_q <= run_en_d;
		end
	end
	assign core_reset = core_reset_q;
	assign reset_pin_out = pin_out_q;
	assign reset_pin_oe_n = pin_oe_n_q;
	assign core_fetch_start = fetch_q;
	assign core_fetch_addr = scr_pkg::RESET_VECTOR;
	assign pll_mult = mult_q;
	assign pll_div = div_q;
	assign boot_mode = boot_q;
	assign wb_dat_o = rdat_q;
	assign wb_ack_o = ack_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_release;
		state_q == scr_pkg::ST_HELD && !held;
	endsequence
	property p_lock_wait;
		@(posedge mclk) disable iff (srst || held)
		s_release |=> (state_q == scr_pkg::ST_LOCK && core_reset_q)[*8];
	endproperty
	a_lock_wait: assert property (p_lock_wait) else $error("Core left reset early");
	property p_lock_exit;
		@(posedge mclk) disable iff (srst)
		$fell(core_reset_q) |-> $past(state_q) == scr_pkg::ST_LOCK &&
			$past(cnt_q) == 16'(LOCK_COUNT - 1);
	endproperty
	a_lock_exit: assert property (p_lock_exit) else $error("Core released off count");
	property p_fetch;
		@(posedge mclk) disable iff (srst)
		fetch_q |-> state_q == scr_pkg::ST_RUN && !core_reset_q && $past(cnt_q) == 16'(LOCK_COUNT - 1);
	endproperty
	a_fetch: assert property (p_fetch) else $error("Fetch start misplaced");
	property p_ratio;
		@(posedge mclk) disable iff (srst)
		state_q == scr_pkg::ST_LOCK |-> mult_q ==
			(ratio_q == scr_pkg::RATIO_CODE_32 ? scr_pkg::RATIO_MULT_32 :
			(ratio_q == scr_pkg::RATIO_CODE_16 ? scr_pkg::RATIO_MULT_16 : scr_pkg::RATIO_MULT_8));
	endproperty
	a_ratio: assert property (p_ratio) else $error("Ratio mismatch");
	property p_pin_dir;
		@(posedge mclk) disable iff (srst)
		wr && wb_adr_i == scr_pkg::ADDR_RUN_RST_CTL |=> ##1 reset_pin_oe_n == $past(wb_dat_i[0], 2);
	endproperty
	a_pin_dir: assert property (p_pin_dir) else $error("Pin direction wrong");
	property p_pin_default;
		@(posedge mclk) disable iff (srst)
		!run_en_q |=> !reset_pin_oe_n || run_en_q;
	endproperty
	a_pin_default: assert property (p_pin_default) else $error("Pin not output");
	property p_freq;
		@(posedge mclk) disable iff (srst)
		wr && wb_adr_i == scr_pkg::ADDR_PWR_MGMT_CTL && state_q == scr_pkg::ST_RUN && !held
			|=> pll_mult == $past(wb_dat_i[7:0]) && pll_div == $past(wb_dat_i[15:8]);
	endproperty
	a_freq: assert property (p_freq) else $error("Frequency write lost");
	property p_ack;
		@(posedge mclk) disable iff (srst)
		wb_cyc_i && wb_stb_i && !ack_q |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("Ack timing wrong");
	property p_hold;
		@(posedge mclk) disable iff (srst)
		!rst_n_s |=> core_reset;
	endproperty
	a_hold: assert property (p_hold) else $error("Core ran in reset");
endmodule
`default_nettype wire

// File: testbench/scr_board_model.sv
// Board model: reset supervisor, strap resistors, dual reset pin wiring
// Assumes bench requests change just after mclk edges
`timescale 1ns/1ns
`default_nettype none
module scr_board_model (
	input wire logic mclk,
	input wire logic hold_rst,
	input wire logic pull_rr,
	input wire logic [1:0] ratio_sel,
	input wire logic [2:0] boot_sel,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe_n,
	output logic hw_reset_n,
	output logic [1:0] ratio_strap,
	output logic [2:0] boot_strap,
	output logic reset_pin_in
);
	logic rst_d;
	// ----------------------------------------
	// Supervisor and straps
	// ----------------------------------------
	initial begin
		rst_d = 1'b1;
		hw_reset_n = 1'b0;
		ratio_strap = 2'h0;
		boot_strap = 3'h0;
	end
	// Reset lags straps by a cycle so straps are settled first
	always @(posedge mclk) begin
		ratio_strap <= ratio_sel;
		boot_strap <= boot_sel;
		rst_d <= hold_rst;
		hw_reset_n <= ~rst_d;
	end
	// Pull-up wins when nobody drives the pin, unless pull_rr pulls it low
	assign reset_pin_in = !reset_pin_oe_n ? reset_pin_out : !pull_rr;
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Bench for the start-up sequencer: Wishbone tasks and boot sequences
// Assumes the board model drives all pins; small lock count
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int LK = 16;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic hold_rst = 1'b1, pull_rr = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [1:0] ratio_sel = 2'h0, rs;
	logic [2:0] boot_sel = 3'h0, bs, bm;
	logic [7:0] adr = 8'h00, mul, dv;
	logic [31:0] dw = 32'h0, dr, rd, fa;
	logic ack, hw_n, pin_in, pin_out, oe_n, crst, fst;
	int miscompares = 0, checks_done = 0;
	always #50 mclk = ~mclk;
	scr_board_model scr_board_model_inst (.mclk(mclk), .hold_rst(hold_rst), .pull_rr(pull_rr),
		.ratio_sel(ratio_sel), .boot_sel(boot_sel), .reset_pin_out(pin_out),
		.reset_pin_oe_n(oe_n), .hw_reset_n(hw_n), .ratio_strap(rs), .boot_strap(bs),
		.reset_pin_in(pin_in));
	scr_startup #(.LOCK_COUNT(LK)) scr_startup_inst (.mclk(mclk), .srst(srst),
		.hw_reset_n(hw_n), .ratio_strap(rs), .boot_strap(bs), .reset_pin_in(pin_in),
		.reset_pin_out(pin_out), .reset_pin_oe_n(oe_n), .core_reset(crst),
		.core_fetch_start(fst), .core_fetch_addr(fa), .pll_mult(mul), .pll_div(dv),
		.boot_mode(bm), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(dw), .wb_sel_i(4'hf), .wb_dat_o(dr), .wb_ack_o(ack));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		@(posedge mclk);
		while (ack !== 1'b1 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		rd = dr;
		if (n == 20) chk(32'h1, 32'h0);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge mclk);
	endtask
	// Hardware reset, release, then wait for the first fetch
	task automatic boot(input logic [1:0] r, input logic [2:0] b, input logic [7:0] m);
		int n;
		n = 0;
		ratio_sel <= r;
		boot_sel <= b;
		hold_rst <= 1'b1;
		repeat (6) @(posedge mclk);
		chk({31'h0, crst}, 32'h1);
		hold_rst <= 1'b0;
		while (fst !== 1'b1 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		chk(32'(n), 32'(LK + 6));
		chk({31'h0, crst}, 32'h0);
		chk(fa, scr_pkg::RESET_VECTOR);
		chk({24'h0, mul}, {24'h0, m});
		chk({29'h0, bm}, {29'h0, b});
		chk({30'h0, oe_n, pin_out}, 32'h1);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		chk({13'h0, crst, oe_n, pin_out, mul, dv},
			{13'h0, 3'h4, scr_pkg::RATIO_MULT_8, scr_pkg::RESET_DIV});
		wb(1'b1, scr_pkg::ADDR_PWR_MGMT_CTL, 32'h0000_0305);
		chk({24'h0, mul}, {24'h0, scr_pkg::RATIO_MULT_8});
		boot(2'h0, 3'h1, scr_pkg::RATIO_MULT_8);
		boot(2'h1, 3'h2, scr_pkg::RATIO_MULT_32);
		boot(2'h2, 3'h7, scr_pkg::RATIO_MULT_16);
		boot(2'h3, 3'h4, scr_pkg::RATIO_MULT_8);
		wb(1'b1, scr_pkg::ADDR_PWR_MGMT_CTL, 32'h0000_0305);
		chk({16'h0, dv, mul}, 32'h0000_0305);
		wb(1'b0, scr_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h0000_0067);
		wb(1'b1, 8'h0c, 32'hffff_ffff);
		wb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		// Pin still driven: a board pull must not reach the core
		pull_rr <= 1'b1;
		repeat (6) @(posedge mclk);
		chk({31'h0, crst}, 32'h0);
		wb(1'b1, scr_pkg::ADDR_RUN_RST_CTL, 32'h0000_0001);
		repeat (6) @(posedge mclk);
		chk({30'h0, oe_n, crst}, 32'h3);
		pull_rr <= 1'b0;
		repeat (LK + 12) @(posedge mclk);
		chk({30'h0, oe_n, crst}, 32'h2);
		wb(1'b0, scr_pkg::ADDR_RUN_RST_CTL, 32'h0);
		chk(rd, 32'h0000_0001);
		finish_test;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		miscompares++;
		finish_test;
	end
endmodule
`default_nettype wire
